// ### paafo_map.vh
`ifndef PAAFO_MAP_VH
`define PAAFO_MAP_VH

`define PAAFO_WIDTH     8
`define PAAFO_RST_VEC   8'h00
`define PAAFO_RST_BIT   1'h0
`define PAAFO_ONE_BIT   1'h1
`define PAAFO_BIT_REF   0
`define PAAFO_BIT_CMPP  1
`define PAAFO_BIT_CMPN  2
`define PAAFO_BIT_T0CNT 3
`define PAAFO_BIT_SCK   4
`define PAAFO_BIT_DOUT  5
`define PAAFO_BIT_SDA   6
`define PAAFO_BIT_CAPT  7

`endif

// ### paafo_pin.v
`timescale 1ns/1ns
`include "paafo_map.vh"

// =============================================
// Per-pin override combiner
module paafo_pin
(
    input  wire pullup_override_en,
    input  wire pullup_override_val,
    input  wire direction_override_en,
    input  wire direction_override_val,
    input  wire value_override_en,
    input  wire value_override_val,
    input  wire toggle_override_en,
    input  wire input_en_override_en,
    input  wire input_en_override_val,
    input  wire port_out,
    input  wire dir,
    input  wire pullup_disable,
    input  wire sleep_mode,
    output wire pin_pullup,
    output wire pin_oe,
    output wire pin_out,
    output wire pin_din_en
);

    wire port_seen;
    wire plain_pullup;

    assign port_seen    = port_out ^ toggle_override_en;
    assign plain_pullup = ~dir & port_out & ~pullup_disable;
    assign pin_pullup   = pullup_override_en ? pullup_override_val : plain_pullup;
    assign pin_oe       = direction_override_en ? direction_override_val : dir;
    assign pin_out      = value_override_en ? value_override_val : port_seen;
    assign pin_din_en   = input_en_override_en ? input_en_override_val : ~sleep_mode;

endmodule

// ### paafo_top.v
`timescale 1ns/1ns
`include "paafo_map.vh"

// =============================================
// Port A alternate function override
module paafo_top
#(
    parameter WIDTH = `PAAFO_WIDTH
)
(
    input  wire             sys_clk,
    input  wire             srst,
    // Port registers
    input  wire [WIDTH-1:0] port_out,
    input  wire [WIDTH-1:0] dir,
    input  wire             pullup_disable,
    input  wire             sleep_mode,
    // Pad inputs
    input  wire [WIDTH-1:0] pin_in,
    // Serial unit
    input  wire             serial_wire_mode_hi,
    input  wire             serial_wire_mode_lo,
    input  wire             serial_data_out,
    input  wire             serial_two_wire_data,
    input  wire             serial_clock_hold,
    input  wire             serial_clock_toggle,
    input  wire             serial_start_irq_en,
    // Timers
    input  wire             timer1_compare_a_out,
    input  wire             timer1_compare_a_en,
    input  wire             timer1_compare_b_out,
    input  wire             timer1_compare_b_en,
    input  wire             timer0_compare_b_out,
    input  wire             timer0_compare_b_en,
    // Pin change
    input  wire [WIDTH-1:0] pinchg_src_en,
    input  wire             pinchg_group0_en,
    // Analog
    input  wire [WIDTH-1:0] analog_dis,
    input  wire             ref_select_hi,
    input  wire             ref_select_lo,
    // Pad controls
    output reg  [WIDTH-1:0] pad_pullup,
    output reg  [WIDTH-1:0] pad_oe,
    output reg  [WIDTH-1:0] pad_out,
    output reg  [WIDTH-1:0] pad_din_en,
    // Alternate inputs
    output reg  [WIDTH-1:0] pinchg_src,
    output reg              timer1_capture_in,
    output reg              timer0_count_in,
    output reg              timer1_count_in,
    output reg              serial_three_wire_clock,
    output reg              serial_data_in,
    output reg              comparator_pos_in,
    output reg              comparator_neg_in,
    output reg  [WIDTH-1:0] analog_ch_route
);

    // =============================================
    // Decoding helpers
    function pc_armed;
        input [WIDTH-1:0] src_en;
        input             grp_en;
        input integer     idx;
        begin
            pc_armed = src_en[idx] & grp_en;
        end
    endfunction

    function dien_ovr_en;
        input armed;
        input extra;
        input adis;
        begin
            dien_ovr_en = armed | extra | adis;
        end
    endfunction

    function od_drive;
        input pull_low;
        input port_bit;
        input dir_bit;
        begin
            od_drive = (pull_low | ~port_bit) & dir_bit;
        end
    endfunction

    function dien_ovr_val;
        input arm;
        input extra;
        begin
            dien_ovr_val = arm | extra;
        end
    endfunction

    // =============================================
    // Out-of-reset term
    reg run_ok;

    always @(posedge sys_clk)
    begin
        if (srst)
            run_ok <= `PAAFO_RST_BIT;
        else
            run_ok <= `PAAFO_ONE_BIT;
    end

    // =============================================
    // Mode decode
    wire three_wire;
    wire two_wire;
    wire ref_ext;
    wire sda_drive;
    wire [WIDTH-1:0] armed;

    assign three_wire = ~serial_wire_mode_hi & serial_wire_mode_lo;
    assign two_wire   = serial_wire_mode_hi;
    assign ref_ext    = (~ref_select_hi & ref_select_lo) | (ref_select_hi & ref_select_lo);
    assign sda_drive  = two_wire & dir[`PAAFO_BIT_SDA];

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : gen_armed
            assign armed[g] = pc_armed(pinchg_src_en, pinchg_group0_en, g);
        end
    endgenerate

    // =============================================
    // Override signal vectors
    wire [WIDTH-1:0] pullup_override_en;
    wire [WIDTH-1:0] pullup_override_val;
    wire [WIDTH-1:0] direction_override_en;
    wire [WIDTH-1:0] direction_override_val;
    wire [WIDTH-1:0] value_override_en;
    wire [WIDTH-1:0] value_override_val;
    wire [WIDTH-1:0] toggle_override_en;
    wire [WIDTH-1:0] input_en_override_en;
    wire [WIDTH-1:0] input_en_override_val;

    // Bit 0: reference pin
    assign pullup_override_en[`PAAFO_BIT_REF]     = run_ok & ref_ext;
    assign pullup_override_val[`PAAFO_BIT_REF]    = `PAAFO_RST_BIT;
    assign direction_override_en[`PAAFO_BIT_REF]  = run_ok & ref_ext;
    assign direction_override_val[`PAAFO_BIT_REF] = `PAAFO_RST_BIT;
    assign value_override_en[`PAAFO_BIT_REF]      = run_ok & ref_ext;
    assign value_override_val[`PAAFO_BIT_REF]     = `PAAFO_RST_BIT;
    assign toggle_override_en[`PAAFO_BIT_REF]     = `PAAFO_RST_BIT;
    assign input_en_override_en[`PAAFO_BIT_REF]   =
        dien_ovr_en(armed[`PAAFO_BIT_REF], `PAAFO_RST_BIT, analog_dis[`PAAFO_BIT_REF]);
    assign input_en_override_val[`PAAFO_BIT_REF]  = armed[`PAAFO_BIT_REF];

    // Bits 1 to 3: plain pins with pin-change and analog
    generate
        for (g = `PAAFO_BIT_CMPP; g <= `PAAFO_BIT_T0CNT; g = g + 1)
        begin : gen_plain
            assign pullup_override_en[g]     = `PAAFO_RST_BIT;
            assign pullup_override_val[g]    = `PAAFO_RST_BIT;
            assign direction_override_en[g]  = `PAAFO_RST_BIT;
            assign direction_override_val[g] = `PAAFO_RST_BIT;
            assign value_override_en[g]      = `PAAFO_RST_BIT;
            assign value_override_val[g]     = `PAAFO_RST_BIT;
            assign toggle_override_en[g]     = `PAAFO_RST_BIT;
            assign input_en_override_en[g]   = dien_ovr_en(armed[g], `PAAFO_RST_BIT, analog_dis[g]);
            assign input_en_override_val[g]  = armed[g];
        end
    endgenerate

    // Bit 4: serial clock
    assign pullup_override_en[`PAAFO_BIT_SCK]     = `PAAFO_RST_BIT;
    assign pullup_override_val[`PAAFO_BIT_SCK]    = `PAAFO_RST_BIT;
    assign direction_override_en[`PAAFO_BIT_SCK]  = two_wire;
    assign direction_override_val[`PAAFO_BIT_SCK] =
        od_drive(serial_clock_hold, port_out[`PAAFO_BIT_SCK], dir[`PAAFO_BIT_SCK]);
    assign value_override_en[`PAAFO_BIT_SCK]      = two_wire & dir[`PAAFO_BIT_SCK];
    assign value_override_val[`PAAFO_BIT_SCK]     = `PAAFO_RST_BIT;
    assign toggle_override_en[`PAAFO_BIT_SCK]     = serial_clock_toggle;
    assign input_en_override_en[`PAAFO_BIT_SCK]   =
        dien_ovr_en(armed[`PAAFO_BIT_SCK], serial_start_irq_en, analog_dis[`PAAFO_BIT_SCK]);
    assign input_en_override_val[`PAAFO_BIT_SCK]  = dien_ovr_val(armed[`PAAFO_BIT_SCK], serial_start_irq_en);

    // Bit 5: serial data-out and compare B
    assign pullup_override_en[`PAAFO_BIT_DOUT]     = `PAAFO_RST_BIT;
    assign pullup_override_val[`PAAFO_BIT_DOUT]    = `PAAFO_RST_BIT;
    assign direction_override_en[`PAAFO_BIT_DOUT]  = `PAAFO_RST_BIT;
    assign direction_override_val[`PAAFO_BIT_DOUT] = `PAAFO_RST_BIT;
    assign value_override_en[`PAAFO_BIT_DOUT]      = three_wire | timer1_compare_b_en;
    assign value_override_val[`PAAFO_BIT_DOUT]     =
        three_wire ? serial_data_out : timer1_compare_b_out;
    assign toggle_override_en[`PAAFO_BIT_DOUT]     = `PAAFO_RST_BIT;
    assign input_en_override_en[`PAAFO_BIT_DOUT]   =
        dien_ovr_en(armed[`PAAFO_BIT_DOUT], `PAAFO_RST_BIT, analog_dis[`PAAFO_BIT_DOUT]);
    assign input_en_override_val[`PAAFO_BIT_DOUT]  = armed[`PAAFO_BIT_DOUT];

    // Bit 6: serial data and compare A
    assign pullup_override_en[`PAAFO_BIT_SDA]     = `PAAFO_RST_BIT;
    assign pullup_override_val[`PAAFO_BIT_SDA]    = `PAAFO_RST_BIT;
    assign direction_override_en[`PAAFO_BIT_SDA]  = two_wire;
    assign direction_override_val[`PAAFO_BIT_SDA] =
        od_drive(~serial_two_wire_data, port_out[`PAAFO_BIT_SDA], dir[`PAAFO_BIT_SDA]);
    assign value_override_en[`PAAFO_BIT_SDA]      = sda_drive | timer1_compare_a_en;
    assign value_override_val[`PAAFO_BIT_SDA]     = ~sda_drive & timer1_compare_a_out;
    assign toggle_override_en[`PAAFO_BIT_SDA]     = `PAAFO_RST_BIT;
    assign input_en_override_en[`PAAFO_BIT_SDA]   =
        dien_ovr_en(armed[`PAAFO_BIT_SDA], serial_start_irq_en, analog_dis[`PAAFO_BIT_SDA]);
    assign input_en_override_val[`PAAFO_BIT_SDA]  = dien_ovr_val(armed[`PAAFO_BIT_SDA], serial_start_irq_en);

    // Bit 7: timer 0 compare B and capture
    assign pullup_override_en[`PAAFO_BIT_CAPT]     = `PAAFO_RST_BIT;
    assign pullup_override_val[`PAAFO_BIT_CAPT]    = `PAAFO_RST_BIT;
    assign direction_override_en[`PAAFO_BIT_CAPT]  = `PAAFO_RST_BIT;
    assign direction_override_val[`PAAFO_BIT_CAPT] = `PAAFO_RST_BIT;
    assign value_override_en[`PAAFO_BIT_CAPT]      = timer0_compare_b_en;
    assign value_override_val[`PAAFO_BIT_CAPT]     = timer0_compare_b_out;
    assign toggle_override_en[`PAAFO_BIT_CAPT]     = `PAAFO_RST_BIT;
    assign input_en_override_en[`PAAFO_BIT_CAPT]   =
        dien_ovr_en(armed[`PAAFO_BIT_CAPT], `PAAFO_RST_BIT, analog_dis[`PAAFO_BIT_CAPT]);
    assign input_en_override_val[`PAAFO_BIT_CAPT]  = armed[`PAAFO_BIT_CAPT];

    // =============================================
    // Per-pin combiners
    wire [WIDTH-1:0] next_pad_pullup;
    wire [WIDTH-1:0] next_pad_oe;
    wire [WIDTH-1:0] next_pad_out;
    wire [WIDTH-1:0] next_pad_din_en;
    wire [WIDTH-1:0] din;

    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : gen_pin
            paafo_pin u_pin
            (
                .pullup_override_en     (pullup_override_en[g]),
                .pullup_override_val    (pullup_override_val[g]),
                .direction_override_en  (direction_override_en[g]),
                .direction_override_val (direction_override_val[g]),
                .value_override_en      (value_override_en[g]),
                .value_override_val     (value_override_val[g]),
                .toggle_override_en     (toggle_override_en[g]),
                .input_en_override_en   (input_en_override_en[g]),
                .input_en_override_val  (input_en_override_val[g]),
                .port_out               (port_out[g]),
                .dir                    (dir[g]),
                .pullup_disable         (pullup_disable),
                .sleep_mode             (sleep_mode),
                .pin_pullup             (next_pad_pullup[g]),
                .pin_oe                 (next_pad_oe[g]),
                .pin_out                (next_pad_out[g]),
                .pin_din_en             (next_pad_din_en[g])
            );
            assign din[g] = pin_in[g] & next_pad_din_en[g];
        end
    endgenerate

    // =============================================
    // Registered pad controls
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            pad_pullup              <= `PAAFO_RST_VEC;
            pad_oe                  <= `PAAFO_RST_VEC;
            pad_out                 <= `PAAFO_RST_VEC;
            pad_din_en              <= `PAAFO_RST_VEC;
        end
        else
        begin
            pad_pullup              <= next_pad_pullup;
            pad_oe                  <= next_pad_oe;
            pad_out                 <= next_pad_out;
            pad_din_en              <= next_pad_din_en;
        end
    end

    // =============================================
    // Registered alternate inputs
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            pinchg_src              <= `PAAFO_RST_VEC;
            timer1_capture_in       <= `PAAFO_RST_BIT;
            timer0_count_in         <= `PAAFO_RST_BIT;
            timer1_count_in         <= `PAAFO_RST_BIT;
            serial_three_wire_clock <= `PAAFO_RST_BIT;
            serial_data_in          <= `PAAFO_RST_BIT;
            comparator_pos_in       <= `PAAFO_RST_BIT;
            comparator_neg_in       <= `PAAFO_RST_BIT;
            analog_ch_route         <= `PAAFO_RST_VEC;
        end
        else
        begin
            pinchg_src              <= din;
            timer1_capture_in       <= din[`PAAFO_BIT_CAPT];
            timer0_count_in         <= din[`PAAFO_BIT_T0CNT];
            timer1_count_in         <= din[`PAAFO_BIT_SCK];
            serial_three_wire_clock <= din[`PAAFO_BIT_SCK];
            serial_data_in          <= din[`PAAFO_BIT_SDA];
            comparator_pos_in       <= analog_dis[`PAAFO_BIT_CMPP];
            comparator_neg_in       <= analog_dis[`PAAFO_BIT_CMPN];
            analog_ch_route         <= analog_dis;
        end
    end

endmodule

// ### paafo_checker.sv
`timescale 1ns/1ns
// ========================================
// Pad override checker
module paafo_checker
#(
    parameter WIDTH = 8
)
(
    input wire             sys_clk,
    input wire             srst,
    input wire [WIDTH-1:0] port_out,
    input wire [WIDTH-1:0] dir,
    input wire             pullup_disable,
    input wire [WIDTH-1:0] pin_in,
    input wire             serial_wire_mode_hi,
    input wire             serial_wire_mode_lo,
    input wire             serial_data_out,
    input wire             serial_two_wire_data,
    input wire             serial_clock_hold,
    input wire             serial_clock_toggle,
    input wire             timer0_compare_b_out,
    input wire             timer0_compare_b_en,
    input wire             ref_select_lo,
    input wire [WIDTH-1:0] pad_pullup,
    input wire [WIDTH-1:0] pad_oe,
    input wire [WIDTH-1:0] pad_out,
    input wire [WIDTH-1:0] pad_din_en,
    input wire [WIDTH-1:0] pinchg_src
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    sequence s_three_wire;
        !serial_wire_mode_hi && serial_wire_mode_lo && dir[5];
    endsequence
    // Reference override needs one edge out of reset first
    sequence s_ref_armed;
        1'b1 ##1 ref_select_lo;
    endsequence
    property p_b5_dout;
        s_three_wire |=> pad_oe[5] && pad_out[5] == $past(serial_data_out);
    endproperty
    a_b5_dout: assert property (p_b5_dout) else $error("bit 5 data");
    property p_b5_pull;
        !dir[5] && port_out[5] && !pullup_disable |=> pad_pullup[5];
    endproperty
    a_b5_pull: assert property (p_b5_pull) else $error("bit 5 pull-up");
    property p_b6_od;
        serial_wire_mode_hi |=> pad_oe[6] == $past((!serial_two_wire_data || !port_out[6]) && dir[6]);
    endproperty
    a_b6_od: assert property (p_b6_od) else $error("bit 6 driver");
    property p_b4_hold;
        serial_wire_mode_hi |=> pad_oe[4] == $past((serial_clock_hold || !port_out[4]) && dir[4]);
    endproperty
    a_b4_hold: assert property (p_b4_hold) else $error("bit 4 driver");
    property p_b4_tog;
        serial_clock_toggle && !serial_wire_mode_hi |=> pad_out[4] != $past(port_out[4]);
    endproperty
    a_b4_tog: assert property (p_b4_tog) else $error("bit 4 toggle");
    property p_b7;
        timer0_compare_b_en |=> pad_out[7] == $past(timer0_compare_b_out);
    endproperty
    a_b7: assert property (p_b7) else $error("bit 7 compare");
    property p_ref;
        s_ref_armed |=> !pad_pullup[0] && !pad_oe[0];
    endproperty
    a_ref: assert property (p_ref) else $error("bit 0 reference");
    property p_pinchg;
        1'b1 |=> pinchg_src == ($past(pin_in) & pad_din_en);
    endproperty
    a_pinchg: assert property (p_pinchg) else $error("pin-change sources");
    property p_plain;
        1'b1 |=> pad_oe[3:1] == $past(dir[3:1]) && pad_out[3:1] == $past(port_out[3:1]);
    endproperty
    a_plain: assert property (p_plain) else $error("plain port control");
endmodule

bind paafo_top paafo_checker #(.WIDTH(WIDTH)) u_paafo_checker (.sys_clk, .srst, .port_out, .dir,
    .pullup_disable, .pin_in, .serial_wire_mode_hi, .serial_wire_mode_lo, .serial_data_out,
    .serial_two_wire_data, .serial_clock_hold, .serial_clock_toggle, .timer0_compare_b_out,
    .timer0_compare_b_en, .ref_select_lo, .pad_pullup, .pad_oe, .pad_out, .pad_din_en, .pinchg_src);

// ### paafo_pad_model.sv
`timescale 1ns/1ns
// ========================================
// Pad and outside driver model
module paafo_pad_model
(
    input  wire       sys_clk,
    input  wire [7:0] pad_oe,
    input  wire [7:0] pad_out,
    input  wire [7:0] pad_pullup,
    input  wire [7:0] ext_drive,
    input  wire [7:0] ext_level,
    output wire [7:0] pin_in
);
    reg [7:0] held = 8'h00;
    // Floating pad without pull-up wanders each cycle
    assign pin_in = (pad_oe & pad_out) | (~pad_oe & ext_drive & ext_level)
                  | (~pad_oe & ~ext_drive & (pad_pullup | ~held));
    always @(posedge sys_clk)
        held <= pin_in;
endmodule

// ### testbench.sv
`timescale 1ns/1ns
// ========================================
// Port override bench
module testbench;
    reg        sys_clk, srst, pullup_disable, sleep_mode, serial_wire_mode_hi, serial_wire_mode_lo;
    reg        serial_data_out, serial_two_wire_data, serial_clock_hold, serial_clock_toggle;
    reg        serial_start_irq_en, timer1_compare_a_out, timer1_compare_a_en, timer1_compare_b_out;
    reg        timer1_compare_b_en, timer0_compare_b_out, timer0_compare_b_en, pinchg_group0_en;
    reg        ref_select_hi, ref_select_lo;
    reg  [7:0] port_out, dir, pinchg_src_en, analog_dis, ext_level, ext_drive;
    wire [7:0] pin_in, pad_pullup, pad_oe, pad_out, pad_din_en, pinchg_src, analog_ch_route;
    wire       timer1_capture_in, timer0_count_in, timer1_count_in, serial_three_wire_clock;
    wire       serial_data_in, comparator_pos_in, comparator_neg_in;
    integer    fails, checks, cycles, i;
    paafo_top u_paafo_top (.sys_clk, .srst, .port_out, .dir, .pullup_disable, .sleep_mode, .pin_in,
        .serial_wire_mode_hi, .serial_wire_mode_lo, .serial_data_out, .serial_two_wire_data,
        .serial_clock_hold, .serial_clock_toggle, .serial_start_irq_en, .timer1_compare_a_out,
        .timer1_compare_a_en, .timer1_compare_b_out, .timer1_compare_b_en, .timer0_compare_b_out,
        .timer0_compare_b_en, .pinchg_src_en, .pinchg_group0_en, .analog_dis, .ref_select_hi,
        .ref_select_lo, .pad_pullup, .pad_oe, .pad_out, .pad_din_en, .pinchg_src, .timer1_capture_in,
        .timer0_count_in, .timer1_count_in, .serial_three_wire_clock, .serial_data_in,
        .comparator_pos_in, .comparator_neg_in, .analog_ch_route);
    paafo_pad_model u_paafo_pad_model (.sys_clk, .pad_oe, .pad_out, .pad_pullup, .ext_drive, .ext_level,
        .pin_in);
    always #2 sys_clk = ~sys_clk;
    // ========================================
    // Tasks
    task test_done;
        if (fails == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks = checks + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task tick;
        @(posedge sys_clk);
        #1;
    endtask
    task pads(input logic [7:0] e_oe, input logic [7:0] e_out, input logic [7:0] e_pu);
        tick;
        check("pad_oe", pad_oe, e_oe);
        check("pad_out", pad_out, e_out);
        check("pad_pullup", pad_pullup, e_pu);
    endtask
    always @(posedge sys_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 1000)
        begin
            fails = fails + 1;
            test_done;
        end
    end
    // ========================================
    // Tests
    initial
    begin
        {fails, checks, cycles} = 0;
        {sys_clk, srst} = 2'h1;
        {pullup_disable, sleep_mode, serial_wire_mode_hi, serial_wire_mode_lo, serial_data_out} = 0;
        {serial_two_wire_data, serial_clock_hold, serial_clock_toggle, serial_start_irq_en} = 0;
        {timer1_compare_a_out, timer1_compare_a_en, timer1_compare_b_out, timer1_compare_b_en} = 0;
        {timer0_compare_b_out, timer0_compare_b_en, pinchg_group0_en, ref_select_hi, ref_select_lo} = 0;
        {port_out, pinchg_src_en, analog_dis, ext_level, ext_drive} = 0;
        dir = 8'hff;
        repeat (4) @(posedge sys_clk);
        #1;
        check("pad_oe", pad_oe, 8'h00);
        srst = 0;
        dir = 8'ha5;
        port_out = 8'h3c;
        pads(8'ha5, 8'h3c, 8'h18);
        {serial_wire_mode_lo, serial_data_out} = 2'h3;
        dir = 8'h20;
        port_out = 8'h00;
        pads(8'h20, 8'h20, 8'h00);
        {dir, port_out, serial_data_out} = {8'h00, 8'h20, 1'b0};
        {timer1_compare_b_en, timer1_compare_b_out} = 2'h3;
        pads(8'h00, 8'h00, 8'h20);
        {serial_wire_mode_lo, dir, port_out} = {1'b0, 8'h20, 8'h00};
        pads(8'h20, 8'h20, 8'h00);
        {timer1_compare_b_en, timer1_compare_a_en, timer1_compare_a_out} = 3'h3;
        dir = 8'h40;
        pads(8'h40, 8'h40, 8'h00);
        {timer1_compare_a_en, timer0_compare_b_en, timer0_compare_b_out} = 3'h3;
        dir = 8'h80;
        pads(8'h80, 8'h80, 8'h00);
        {timer0_compare_b_en, serial_wire_mode_hi, dir, port_out} = {2'h1, 8'h50, 8'h50};
        for (i = 0; i < 4; i = i + 1)
        begin
            {serial_two_wire_data, serial_clock_hold} = i[1:0];
            pads({1'b0, ~i[1], 1'b0, i[0], 4'h0}, 8'h00, 8'h00);
        end
        {serial_wire_mode_hi, serial_clock_toggle, dir, port_out} = {2'h1, 8'h10, 8'h00};
        pads(8'h10, 8'h10, 8'h00);
        port_out = 8'h10;
        pads(8'h10, 8'h00, 8'h00);
        {serial_clock_toggle, dir, port_out} = 0;
        {sleep_mode, pinchg_group0_en, ext_drive, ext_level} = {2'h3, 8'hff, 8'hff};
        for (i = 0; i < 8; i = i + 1)
        begin
            pinchg_src_en = 8'h01 << i;
            tick;
            check("pad_din_en", pad_din_en, 8'h01 << i);
            check("pinchg_src", pinchg_src, 8'h01 << i);
            check("alt inputs", {3'h0, timer1_capture_in, timer0_count_in, serial_data_in, timer1_count_in,
                serial_three_wire_clock}, {3'h0, i == 7, i == 3, i == 6, i == 4, i == 4});
        end
        {pinchg_src_en, pinchg_group0_en} = {8'hff, 1'b0};
        tick;
        check("pad_din_en", pad_din_en, 8'h00);
        {pinchg_src_en, sleep_mode, analog_dis, serial_start_irq_en} = {8'h00, 1'b0, 8'hff, 1'b1};
        tick;
        check("pad_din_en", pad_din_en, 8'h50);
        check("analog", {5'h0, comparator_pos_in, comparator_neg_in, &analog_ch_route}, 8'h07);
        check("analog_ch_route", analog_ch_route, 8'hff);
        {analog_dis, serial_start_irq_en, ref_select_hi, port_out} = {8'h00, 2'h1, 8'h01};
        pads(8'h00, 8'h01, 8'h01);
        pullup_disable = 1;
        pads(8'h00, 8'h01, 8'h00);
        {pullup_disable, dir} = {1'b0, 8'h01};
        pads(8'h01, 8'h01, 8'h00);
        ref_select_lo = 1;
        pads(8'h00, 8'h00, 8'h00);
        dir = 8'h00;
        pads(8'h00, 8'h00, 8'h00);
        test_done;
    end
endmodule
